// *** aom_consts.svh ***
// Purpose: named offsets, field positions, reset values and counts for the pin mapper
// Assumes: included by the package and the design files by bare name
// Notes: definitions only
`ifndef AOM_CONSTS_SVH
`define AOM_CONSTS_SVH

// register map, byte addresses on the plain register port
`define AOM_CTRL_OFS 8'h00
`define AOM_STAT_OFS 8'h04
`define AOM_CTRL_RST 32'h0000_0000
`define AOM_REF_BUFFER_CTRL_BIT_BIT 24

// result store
`define AOM_NUM_CH 6
`define AOM_LAST_CH 3'h5
`define AOM_FIRST_CH 3'h0
`define AOM_WORD_BITS 16
`define AOM_LANE_BITS 96
`define AOM_LANE_MSB 95

// variant width select and the masks that zero unused upper bits
`define AOM_WID_14 2'h1
`define AOM_WID_12 2'h2
`define AOM_MASK_16 16'hffff
`define AOM_MASK_14 16'h3fff
`define AOM_MASK_12 16'h0fff

// serial lane lengths in bits
`define AOM_LEN_0 7'h00
`define AOM_LEN_2W 7'h20
`define AOM_LEN_3W 7'h30
`define AOM_LEN_4W 7'h40
`define AOM_LEN_6W 7'h60
`define AOM_CNT_FIRST 7'h01
`define AOM_CNT_MAX 7'h7f

// serial clock ceiling in MHz, for reference only
`define AOM_SCLK_MAX_MHZ 36

// pin synchroniser: 12 pins, idle levels after reset
`define AOM_PIN_W 12
`define AOM_PIN_RST 12'h801

`endif

// *** aom_pkg.sv ***
// Purpose: types shared by the pin mapper files
// Assumes: aom_consts.svh holds the numbers
// Notes: no logic here
`include "aom_consts.svh"
package aom_pkg;

	typedef enum logic [1:0] {
		AOM_ST_IDLE = 2'b01,
		AOM_ST_COPY = 2'b10
	} aom_state_t;

	// interface choices captured with each result set
	typedef struct packed {
		logic serial;
		logic sel_b;
		logic sel_c;
		logic chain_en;
	} aom_mode_t;

	typedef logic [`AOM_WORD_BITS-1:0] aom_word_t;

	// one published result set: mode plus A0,A1,B0,B1,C0,C1
	typedef struct packed {
		aom_mode_t mode;
		aom_word_t [`AOM_NUM_CH-1:0] words;
	} aom_snap_t;

endpackage : aom_pkg

// *** aom_result_mem.sv ***
// Purpose: six-entry result store with registered read data
// Assumes: single clock, synchronous reset
// Notes: read data appear one cycle after the address
`timescale 1ns/1ps
`include "aom_consts.svh"
module aom_result_mem (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input wire aom_pkg::aom_word_t wr_data,
	input wire logic [2:0] rd_addr,
	output aom_pkg::aom_word_t rd_data_q
);
	import aom_pkg::*;

	aom_word_t mem_q [`AOM_NUM_CH];

	// one write port per entry; out-of-range addresses are dropped
	genvar gi;
	for (gi = 0; gi < `AOM_NUM_CH; gi++) begin : g_ent
		always_ff @(posedge ref_clk) begin
			if (srst) begin
				mem_q[gi] <= '0;
			end else if (wr_en && wr_addr == 3'(gi)) begin
				mem_q[gi] <= wr_data;
			end
		end
	end

	wire aom_word_t rd_sel = (rd_addr <= `AOM_LAST_CH) ? mem_q[rd_addr] : '0;

	// registered read keeps the copy path short
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rd_data_q <= '0;
		end else begin
			rd_data_q <= rd_sel;
		end
	end

endmodule : aom_result_mem

// *** aom_pin_map.sv ***
// Purpose: maps six conversion results onto the parallel bus or up to three serial lanes
// Assumes: straps and read strobe are pins; serial side runs on the host's serial clock
// Notes: published results stay frozen while a serial frame is open
// How it works
// - strap selects parallel bus or serial lanes
// - hardware mode: buffer pin low enables buffers
// - software mode: control bit gates buffers
// - narrow variants drive unused upper bits zero
// - third select high: channel C on lane C
// - second select: B lane, plus C1 sometimes
// - lane A always, plus C0 without C
// - both selects low: all six on A
// - byte mode: order input picks first byte
// - chain enable turns pins into cascade inputs
// - cascade B, C need their lane selected
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "aom_consts.svh"
module aom_pin_map (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic res_wr,
	input wire logic [2:0] res_ch,
	input wire aom_pkg::aom_word_t res_data,
	input wire logic conv_done,
	input wire logic interface_select,
	input wire logic config_source_select,
	input wire logic ref_buffer_enable_n,
	input wire logic upper_byte_first,
	input wire logic byte_mode,
	input wire logic sel_b,
	input wire logic sel_c,
	input wire logic chain_enable,
	input wire logic [1:0] res_width,
	input wire logic par_rd_n,
	output logic ref_buf_on,
	output logic data_ready,
	output aom_pkg::aom_word_t par_data,
	output logic par_oe,
	output logic serial_oe_a,
	output logic serial_oe_b,
	output logic serial_oe_c,
	input wire logic serial_clk,
	input wire logic frame_n,
	input wire logic chain_in_a,
	input wire logic chain_in_b,
	input wire logic chain_in_c,
	output logic serial_out_a,
	output logic serial_out_b,
	output logic serial_out_c
);
	import aom_pkg::*;

	// ---- pin synchroniser: stage one feeds stage two only
	logic [`AOM_PIN_W-1:0] pin_s1_q, pin_s2_q;
	wire logic [`AOM_PIN_W-1:0] pin_raw = {frame_n, interface_select, config_source_select,
		ref_buffer_enable_n, upper_byte_first, byte_mode, sel_b, sel_c, chain_enable,
		res_width, par_rd_n};
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pin_s1_q <= `AOM_PIN_RST;
			pin_s2_q <= `AOM_PIN_RST;
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
		end
	end

	// named views of the synchronised pins
	wire logic frame_busy = ~pin_s2_q[11];
	wire logic ser_mode = pin_s2_q[10];
	wire logic cfg_sw = pin_s2_q[9];
	wire logic rbuf_n = pin_s2_q[8];
	wire logic hb_first = pin_s2_q[7];
	wire logic byte_sel = pin_s2_q[6];
	wire logic selb_s = pin_s2_q[5];
	wire logic selc_s = pin_s2_q[4];
	wire logic chain_s = pin_s2_q[3];
	wire logic [1:0] wid_s = pin_s2_q[2:1];
	wire logic rd_n_s = pin_s2_q[0];

	// ---- register port
	logic [31:0] ctrl_q, rdata_q;
	aom_state_t state_q, state_d;
	logic ready_q;
	wire logic hit_ctrl = reg_addr == `AOM_CTRL_OFS;
	wire logic hit_stat = reg_addr == `AOM_STAT_OFS;
	wire logic [31:0] stat_val = {18'h0, state_q, ready_q, pin_s2_q[10:0]};
	wire logic [31:0] rd_mux = hit_ctrl ? ctrl_q : (hit_stat ? stat_val : 32'h0);

	// read data live for exactly the cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_q <= `AOM_CTRL_RST;
			rdata_q <= '0;
		end else begin
			if (reg_wr && hit_ctrl) ctrl_q <= reg_wdata;
			rdata_q <= reg_rd ? rd_mux : 32'h0;
		end
	end
	assign reg_rdata = rdata_q;

	// ---- reference buffer gate; pin is a data bit in parallel mode, so hardware mode keeps buffers on
	logic rbuf_on_q;
	wire logic rbuf_sw = ~ctrl_q[`AOM_REF_BUFFER_CTRL_BIT_BIT];
	wire logic rbuf_hw = ser_mode ? ~rbuf_n : 1'b1;
	always_ff @(posedge ref_clk) begin
		if (srst) rbuf_on_q <= 1'b1;
		else rbuf_on_q <= cfg_sw ? rbuf_sw : rbuf_hw;
	end
	assign ref_buf_on = rbuf_on_q;

	// ---- result store and copy into the published set
	logic pend_q, cp_vld_q;
	logic [2:0] rd_addr_q, cp_idx_q;
	aom_word_t mem_rd;
	aom_snap_t snap_q;
	aom_result_mem u_mem (
		.ref_clk(ref_clk),
		.srst(srst),
		.wr_en(res_wr),
		.wr_addr(res_ch),
		.wr_data(res_data),
		.rd_addr(rd_addr_q),
		.rd_data_q(mem_rd)
	);

	wire logic copy_go = state_q == AOM_ST_IDLE && pend_q && !frame_busy;
	wire logic copy_last = state_q == AOM_ST_COPY && rd_addr_q == `AOM_LAST_CH;
	wire logic [15:0] wmask = (wid_s == `AOM_WID_14) ? `AOM_MASK_14 :
		((wid_s == `AOM_WID_12) ? `AOM_MASK_12 : `AOM_MASK_16);
	wire aom_mode_t mode_now = '{serial: ser_mode, sel_b: selb_s, sel_c: selc_s,
		chain_en: chain_s};

	always_comb begin
		state_d = state_q;
		case (state_q)
			AOM_ST_IDLE: if (copy_go) state_d = AOM_ST_COPY;
			AOM_ST_COPY: if (copy_last) state_d = AOM_ST_IDLE;
			default: state_d = AOM_ST_IDLE;
		endcase
	end

	// a new conversion during the copy stays pending rather than lost
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_q <= AOM_ST_IDLE;
			pend_q <= 1'b0;
			rd_addr_q <= `AOM_FIRST_CH;
			cp_vld_q <= 1'b0;
			cp_idx_q <= `AOM_FIRST_CH;
		end else begin
			state_q <= state_d;
			pend_q <= conv_done | (pend_q & ~copy_go);
			rd_addr_q <= (state_q == AOM_ST_COPY && !copy_last) ? rd_addr_q + 3'h1 :
				`AOM_FIRST_CH;
			cp_vld_q <= state_q == AOM_ST_COPY;
			cp_idx_q <= rd_addr_q;
		end
	end

	// unused upper bits are cleared as words enter the set
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			snap_q <= '0;
			ready_q <= 1'b0;
		end else begin
			if (copy_go) snap_q.mode <= mode_now;
			if (cp_vld_q) snap_q.words[cp_idx_q] <= mem_rd & wmask;
			if (copy_go) ready_q <= 1'b0;
			else if (cp_vld_q && cp_idx_q == `AOM_LAST_CH) ready_q <= 1'b1;
		end
	end
	assign data_ready = ready_q;

	// ---- parallel readout on the falling read strobe
	logic rd_n_d_q, phase_q, par_oe_q;
	logic [2:0] par_idx_q;
	aom_word_t par_q;
	wire logic rd_fall = rd_n_d_q & ~rd_n_s;
	wire aom_word_t par_word = snap_q.words[par_idx_q];
	wire logic upper_now = hb_first ^ phase_q;
	wire aom_word_t byte_val = {upper_now ? par_word[15:8] : par_word[7:0], 8'h00};
	wire logic word_done = !byte_sel || phase_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rd_n_d_q <= 1'b1;
			phase_q <= 1'b0;
			par_idx_q <= `AOM_FIRST_CH;
			par_q <= '0;
			par_oe_q <= 1'b0;
		end else begin
			rd_n_d_q <= rd_n_s;
			par_oe_q <= !ser_mode && !rd_n_s;
			if (copy_go) begin
				phase_q <= 1'b0;
				par_idx_q <= `AOM_FIRST_CH;
			end else if (rd_fall && !ser_mode) begin
				par_q <= byte_sel ? byte_val : par_word;
				phase_q <= byte_sel & ~phase_q;
				if (word_done) par_idx_q <= (par_idx_q == `AOM_LAST_CH) ? `AOM_FIRST_CH :
					par_idx_q + 3'h1;
			end
		end
	end
	assign par_data = par_q;
	assign par_oe = par_oe_q;

	// ---- serial lane enables follow the live straps
	logic [2:0] soe_q;
	always_ff @(posedge ref_clk) begin
		if (srst) soe_q <= 3'h0;
		else soe_q <= {ser_mode & selc_s, ser_mode & selb_s, ser_mode};
	end
	assign serial_oe_a = soe_q[0];
	assign serial_oe_b = soe_q[1];
	assign serial_oe_c = soe_q[2];

	// ---- link domain: the set is frozen while a frame is open, so it is read directly
	wire aom_mode_t lm = snap_q.mode;
	wire aom_word_t [`AOM_NUM_CH-1:0] w = snap_q.words;
	logic [2:0][`AOM_LANE_MSB:0] lane_bits;
	logic [2:0][6:0] lane_len;
	logic [2:0] chain_ok, chain_pin;
	assign chain_pin = {chain_in_c, chain_in_b, chain_in_a};

	// lane A collects whatever has no lane of its own, except C1, which lane B takes when selected
	assign lane_bits[0] = (!lm.sel_b && !lm.sel_c) ? {w[0], w[1], w[2], w[3], w[4], w[5]} :
		(!lm.sel_c ? {w[0], w[1], w[4], 48'h0} :
		(!lm.sel_b ? {w[0], w[1], w[2], w[3], 32'h0} : {w[0], w[1], 64'h0}));
	assign lane_len[0] = (!lm.sel_b && !lm.sel_c) ? `AOM_LEN_6W :
		(!lm.sel_c ? `AOM_LEN_3W : (!lm.sel_b ? `AOM_LEN_4W : `AOM_LEN_2W));
	assign lane_bits[1] = lm.sel_c ? {w[2], w[3], 64'h0} : {w[2], w[3], w[5], 48'h0};
	assign lane_len[1] = !lm.sel_b ? `AOM_LEN_0 : (lm.sel_c ? `AOM_LEN_2W : `AOM_LEN_3W);
	assign lane_bits[2] = {w[4], w[5], 64'h0};
	assign lane_len[2] = lm.sel_c ? `AOM_LEN_2W : `AOM_LEN_0;

	// cascade pins count only in serial chain mode with their lane live
	assign chain_ok[0] = lm.serial & lm.chain_en;
	assign chain_ok[1] = lm.serial & lm.chain_en & lm.sel_b;
	assign chain_ok[2] = lm.serial & lm.chain_en & lm.sel_c;

	// frame start flag cleared by the frame's own signal, since the clock may stop
	logic started_q;
	always_ff @(posedge serial_clk or posedge frame_n) begin
		if (frame_n) started_q <= 1'b0;
		else started_q <= 1'b1;
	end
	wire logic load_now = !started_q;

	logic [2:0] sout_q;
	genvar gl;
	for (gl = 0; gl < 3; gl++) begin : g_lane
		logic [`AOM_LANE_MSB:0] sh_q;
		logic [6:0] cnt_q;
		logic out_q; // one register per lane keeps each output bit single-driven
		wire logic cbit = chain_ok[gl] & chain_pin[gl];
		wire logic own = cnt_q < lane_len[gl];
		// first edge presents the MSB, later edges one bit each; cascade data trail own data
		always_ff @(posedge serial_clk) begin
			if (load_now) begin
				out_q <= (lane_len[gl] != `AOM_LEN_0) ? lane_bits[gl][`AOM_LANE_MSB] : cbit;
				sh_q <= {lane_bits[gl][`AOM_LANE_MSB-1:0], 1'b0};
				cnt_q <= `AOM_CNT_FIRST;
			end else begin
				out_q <= own ? sh_q[`AOM_LANE_MSB] : cbit;
				sh_q <= {sh_q[`AOM_LANE_MSB-1:0], 1'b0};
				if (cnt_q != `AOM_CNT_MAX) cnt_q <= cnt_q + 7'h01;
			end
		end
		assign sout_q[gl] = out_q;
	end
	assign serial_out_a = sout_q[0];
	assign serial_out_b = sout_q[1];
	assign serial_out_c = sout_q[2];

	// ---- checks
	chk_par_oe_mode: assert property (@(posedge ref_clk) disable iff (srst)
		par_oe_q |-> !$past(ser_mode) && !soe_q[0])
		else $error("parallel bus driven in serial mode");
	chk_ref_buffer_ctrl_bit_hw: assert property (@(posedge ref_clk) disable iff (srst)
		(!cfg_sw && ser_mode) |=> rbuf_on_q == !$past(rbuf_n))
		else $error("hardware buffer gate wrong");
	chk_ref_buffer_ctrl_bit_sw: assert property (@(posedge ref_clk) disable iff (srst)
		cfg_sw && $stable(ctrl_q) |=> rbuf_on_q == !$past(ctrl_q[`AOM_REF_BUFFER_CTRL_BIT_BIT]))
		else $error("software buffer gate wrong");
	chk_narrow_zero: assert property (@(posedge ref_clk) disable iff (srst)
		cp_vld_q && wid_s == `AOM_WID_12 |=> snap_q.words[$past(cp_idx_q)][15:12] == 4'h0)
		else $error("upper bits not cleared");
	chk_lane_c_oe: assert property (@(posedge ref_clk) disable iff (srst)
		ser_mode && selc_s [*2] |-> soe_q[2])
		else $error("lane C not enabled");
	chk_lane_b_oe: assert property (@(posedge ref_clk) disable iff (srst)
		!selb_s |=> !soe_q[1])
		else $error("lane B driven when unselected");
	chk_lane_a_len: assert property (@(posedge ref_clk) disable iff (srst)
		!lm.sel_b && !lm.sel_c |-> lane_len[0] == `AOM_LEN_6W && lane_len[2] == `AOM_LEN_0)
		else $error("single lane does not carry six words");
	chk_byte_order: assert property (@(posedge ref_clk) disable iff (srst)
		rd_fall && !ser_mode && byte_sel && !phase_q && hb_first && !copy_go
		|=> par_q[15:8] == $past(par_word[15:8]) && phase_q)
		else $error("first byte order wrong");
	chk_msb_first: assert property (@(posedge serial_clk) disable iff (frame_n)
		load_now && lane_len[0] != `AOM_LEN_0 |=> sout_q[0] == $past(lane_bits[0][`AOM_LANE_MSB]))
		else $error("lane A did not start with MSB");
	chk_chain_gate: assert property (@(posedge serial_clk) disable iff (frame_n)
		!load_now && !chain_ok[1] && g_lane[1].cnt_q >= lane_len[1] |=> !sout_q[1])
		else $error("lane B cascade leaked");
	cov_copy: cover property (@(posedge ref_clk) disable iff (srst)
		cp_vld_q && cp_idx_q == `AOM_LAST_CH);
	cov_byte_pair: cover property (@(posedge ref_clk) disable iff (srst)
		rd_fall && byte_sel && phase_q);
	cov_three_lanes: cover property (@(posedge serial_clk) disable iff (frame_n)
		load_now && lm.sel_b && lm.sel_c);
	cov_chain_a: cover property (@(posedge serial_clk) disable iff (frame_n)
		chain_ok[0] && g_lane[0].cnt_q > lane_len[0]);

endmodule : aom_pin_map

// *** aom_host_model.sv ***
// Purpose: host side of the serial link: frame, serial clock, capture, cascade lines
// Assumes: one frame at a time, started by the bench through run_frame
// Notes: the clock stands still low between frames, as a real host leaves it
`timescale 1ns/1ps
module aom_host_model (
	output logic serial_clk,
	output logic frame_n,
	output logic chain_in_a,
	output logic chain_in_b,
	output logic chain_in_c,
	input wire logic chain_drive,
	input wire logic serial_out_a,
	input wire logic serial_out_b,
	input wire logic serial_out_c
);
	logic [111:0] cap_a, cap_b, cap_c;
	// cascade lines high under test, else tied low as an unused chain must be
	assign chain_in_a = chain_drive;
	assign chain_in_b = chain_drive;
	assign chain_in_c = chain_drive;
	// a short low pulse at start clears the frame-start flag, which has no other reset
	initial begin
		serial_clk = 1'b0;
		frame_n = 1'b0;
		#1;
		frame_n = 1'b1;
	end
	// frame is set up well ahead of the first edge; bits are taken on falling edges
	task run_frame(input int nbits);
		frame_n = 1'b0;
		#7;
		repeat (nbits) begin
			serial_clk = 1'b1;
			#3;
			serial_clk = 1'b0;
			cap_a = {cap_a[110:0], serial_out_a};
			cap_b = {cap_b[110:0], serial_out_b};
			cap_c = {cap_c[110:0], serial_out_c};
			#3;
		end
		frame_n = 1'b1;
	endtask : run_frame
endmodule : aom_host_model

// *** aom_pin_map_tb.sv ***
// Purpose: self-checking bench for the output pin mapper
// Assumes: host model makes the serial clock; pins move only between transfers
// Notes: every scenario publishes a fresh result set before reading it back
`timescale 1ns/1ps
`include "aom_consts.svh"
module aom_pin_map_tb;
	import aom_pkg::*;
	logic ref_clk, srst, reg_wr, reg_rd, res_wr, conv_done, interface_select;
	logic config_source_select, ref_buffer_enable_n, upper_byte_first, byte_mode;
	logic sel_b, sel_c, chain_enable, par_rd_n, ref_buf_on, data_ready, par_oe;
	logic serial_oe_a, serial_oe_b, serial_oe_c, serial_clk, frame_n, chain_drive;
	logic chain_in_a, chain_in_b, chain_in_c, serial_out_a, serial_out_b, serial_out_c;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [2:0] res_ch;
	logic [1:0] res_width;
	aom_word_t res_data, par_data;
	aom_word_t wd [6] = '{16'hf1a5, 16'he2b6, 16'hd3c7, 16'hc4d8, 16'hb5e9, 16'ha6fa};
	int err_count, compares, cycles;

	aom_pin_map uut (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.res_wr, .res_ch, .res_data, .conv_done, .interface_select, .config_source_select,
		.ref_buffer_enable_n, .upper_byte_first, .byte_mode, .sel_b, .sel_c, .chain_enable,
		.res_width, .par_rd_n, .ref_buf_on, .data_ready, .par_data, .par_oe, .serial_oe_a,
		.serial_oe_b, .serial_oe_c, .serial_clk, .frame_n, .chain_in_a, .chain_in_b,
		.chain_in_c, .serial_out_a, .serial_out_b, .serial_out_c);
	aom_host_model host (.serial_clk, .frame_n, .chain_in_a, .chain_in_b, .chain_in_c,
		.chain_drive, .serial_out_a, .serial_out_b, .serial_out_c);

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// a hang ends the run here instead of stalling forever
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			test_done();
		end
	end

	task test_done;
		$display("comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	task chk_val(input string n, input logic [111:0] e, input logic [111:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk_val

	task chk_bit(input string n, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %b, seen %b", n, e, g);
		end
	endtask : chk_bit

	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	task reg_write(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : reg_write

	// read data stand only in the cycle after the strobe
	task reg_read(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk_val("reg_rdata", 112'(e), 112'(reg_rdata));
		@(posedge ref_clk);
	endtask : reg_read

	// six results then a publish; waits for the set to be complete
	task load_set;
		for (int i = 0; i < 6; i++) begin
			res_wr <= 1'b1;
			res_ch <= 3'(i);
			res_data <= wd[i];
			@(posedge ref_clk);
		end
		res_wr <= 1'b0;
		conv_done <= 1'b1;
		@(posedge ref_clk);
		conv_done <= 1'b0;
		cyc(3);
		for (int k = 0; k < 40 && data_ready !== 1'b1; k++) @(posedge ref_clk);
		chk_bit("data_ready", 1'b1, data_ready);
	endtask : load_set

	// strobes stay long enough for the pin synchroniser on both levels
	task par_read(input aom_word_t e, input logic oe);
		par_rd_n <= 1'b0;
		cyc(5);
		chk_bit("par_oe", oe, par_oe);
		if (oe)
			chk_val("par_data", 112'(e), 112'(par_data));
		par_rd_n <= 1'b1;
		cyc(5);
	endtask : par_read

	function automatic logic [111:0] lane(input logic [95:0] w, input int n, input logic f);
		logic [111:0] r;
		r = {112{f}};
		for (int i = 0; i < n * 16; i++) r[111 - i] = w[95 - i];
		return r;
	endfunction : lane

	task t_regs;
		reg_read(`AOM_CTRL_OFS, `AOM_CTRL_RST);
		reg_write(8'h08, 32'hffff_ffff);
		reg_read(8'h08, 32'h0000_0000);
		reg_read(`AOM_CTRL_OFS, `AOM_CTRL_RST);
	endtask : t_regs

	task t_ref_buffer_ctrl_bit;
		interface_select <= 1'b1;
		ref_buffer_enable_n <= 1'b0;
		cyc(5);
		chk_bit("ref_buf_on", 1'b1, ref_buf_on);
		ref_buffer_enable_n <= 1'b1;
		cyc(5);
		chk_bit("ref_buf_on", 1'b0, ref_buf_on);
		config_source_select <= 1'b1;
		reg_write(`AOM_CTRL_OFS, 32'h0100_0000);
		cyc(5);
		chk_bit("ref_buf_on", 1'b0, ref_buf_on);
		reg_read(`AOM_CTRL_OFS, 32'h0100_0000);
		reg_write(`AOM_CTRL_OFS, `AOM_CTRL_RST);
		cyc(5);
		chk_bit("ref_buf_on", 1'b1, ref_buf_on);
	endtask : t_ref_buffer_ctrl_bit

	// each variant width zeroes the unused upper bits; index steps per strobe
	task t_par;
		aom_word_t m;
		logic [31:0] st;
		interface_select <= 1'b0;
		for (int w = 0; w < 3; w++) begin
			m = (w == 2) ? `AOM_MASK_12 : (w == 1) ? `AOM_MASK_14 : `AOM_MASK_16;
			res_width <= 2'(w);
			cyc(5);
			load_set();
			// status: idle copy engine, complete set, then the synced straps
			st = {18'h0, 2'h1, 1'b1, interface_select, config_source_select, ref_buffer_enable_n,
				upper_byte_first, byte_mode, sel_b, sel_c, chain_enable, res_width, par_rd_n};
			reg_read(`AOM_STAT_OFS, st);
			chk_bit("serial_oe_a", 1'b0, serial_oe_a);
			par_read(wd[0] & m, 1'b1);
			par_read(wd[1] & m, 1'b1);
		end
		res_width <= 2'h0;
	endtask : t_par

	task t_byte;
		byte_mode <= 1'b1;
		for (int u = 0; u < 2; u++) begin
			upper_byte_first <= u[0];
			cyc(5);
			load_set();
			par_read({u[0] ? wd[0][15:8] : wd[0][7:0], 8'h00}, 1'b1);
			par_read({u[0] ? wd[0][7:0] : wd[0][15:8], 8'h00}, 1'b1);
		end
		byte_mode <= 1'b0;
	endtask : t_byte

	// every lane select pairing, chained and unchained
	task t_serial;
		logic [111:0] ea, eb, ec;
		logic b, c, ch;
		interface_select <= 1'b1;
		for (int m = 0; m < 8; m++) begin
			{ch, c, b} = 3'(m);
			sel_b <= b;
			sel_c <= c;
			chain_enable <= ch;
			chain_drive <= ch;
			cyc(5);
			load_set();
			host.run_frame(112);
			cyc(1);
			chk_bit("serial_oe_a", 1'b1, serial_oe_a);
			chk_bit("serial_oe_b", b, serial_oe_b);
			chk_bit("serial_oe_c", c, serial_oe_c);
			case ({b, c})
				2'b00: ea = lane({wd[0], wd[1], wd[2], wd[3], wd[4], wd[5]}, 6, ch);
				2'b10: ea = lane({wd[0], wd[1], wd[4], 48'h0}, 3, ch);
				2'b01: ea = lane({wd[0], wd[1], wd[2], wd[3], 32'h0}, 4, ch);
				default: ea = lane({wd[0], wd[1], 64'h0}, 2, ch);
			endcase
			eb = lane({wd[2], wd[3], wd[5], 48'h0}, b ? (c ? 2 : 3) : 0, ch & b);
			ec = lane({wd[4], wd[5], 64'h0}, c ? 2 : 0, ch & c);
			chk_val("lane_a", ea, host.cap_a);
			chk_val("lane_b", eb, host.cap_b);
			chk_val("lane_c", ec, host.cap_c);
			par_read(16'h0000, 1'b0);
		end
	endtask : t_serial

	// a reset in mid-run returns data_ready, ref_buf_on, serial_oe_a and par_oe to their idle levels
	task t_reset;
		reg_write(`AOM_CTRL_OFS, 32'h0100_0000);
		srst <= 1'b1;
		cyc(2);
		chk_bit("data_ready", 1'b0, data_ready);
		chk_bit("ref_buf_on", 1'b1, ref_buf_on);
		chk_bit("serial_oe_a", 1'b0, serial_oe_a);
		chk_bit("par_oe", 1'b0, par_oe);
		srst <= 1'b0;
		cyc(3);
		reg_read(`AOM_CTRL_OFS, `AOM_CTRL_RST);
		cyc(3);
		chk_bit("serial_oe_a", 1'b1, serial_oe_a);
	endtask : t_reset

	initial begin
		{srst, reg_wr, reg_rd, res_wr, conv_done, interface_select} = 6'h01;
		{config_source_select, ref_buffer_enable_n, upper_byte_first, byte_mode} = 4'h0;
		{sel_b, sel_c, chain_enable, chain_drive, par_rd_n} = 5'h01;
		{reg_addr, reg_wdata, res_ch, res_width, res_data} = '0;
		{err_count, compares, cycles} = '0;
		srst = 1'b1;
		cyc(20);
		srst <= 1'b0;
		cyc(3);
		t_regs();
		t_ref_buffer_ctrl_bit();
		config_source_select <= 1'b0;
		t_par();
		t_byte();
		t_serial();
		t_reset();
		test_done();
	end
endmodule : aom_pin_map_tb
